/* File: logic/oag_pkg.sv */
/*
  Constants, modes and types for the operand address generator.
  Assumes nothing of its surroundings.
*/
package oag_pkg;
  localparam int ADDR_W = 16;
  localparam int BANK_COUNT = 4;
  localparam int REG_COUNT = 8;
  localparam logic [15:0] SHORT_LO = 16'hFE20;
  localparam logic [15:0] SHORT_HI = 16'hFF1F;
  localparam logic [7:0] SHORT_SPLIT = 8'h20;
  localparam logic [6:0] SHORT_TOP = 7'h7F;
  localparam logic [7:0] SFR_PAGE = 8'hFF;
  localparam logic [7:0] SFR_GAP_LO = 8'hD0;
  localparam logic [7:0] SFR_GAP_HI = 8'hDF;
  localparam logic [15:0] HSRAM_LO_DEF = 16'hFB00;
  localparam logic [15:0] HSRAM_HI_DEF = 16'hFEFF;
  localparam logic [1:0] PAIR_HL = 2'h3;
  localparam logic [2:0] REG_C = 3'h2;
  localparam logic [2:0] REG_B = 3'h3;

  typedef enum logic [3:0] {
    MODE_REG = 4'h0,
    MODE_DIRECT = 4'h1,
    MODE_SHORT = 4'h2,
    MODE_SFR = 4'h3,
    MODE_INDIRECT = 4'h4,
    MODE_BASED = 4'h5,
    MODE_INDEXED = 4'h6,
    MODE_STACK = 4'h7
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } state_e;
endpackage : oag_pkg

/* File: logic/bank_addr_if.sv */
/*
  Carries a bank register location between generator and register-file map.
  Assumes one clock domain.
*/
`timescale 1ns/100ps
interface bank_addr_if;
  logic [1:0] bank;
  logic [2:0] reg_sel;
  logic wide;
  logic [15:0] loc;
  modport gen (output bank, output reg_sel, output wide, input loc);
  modport map (input bank, input reg_sel, input wide, output loc);
endinterface : bank_addr_if

/* File: logic/bank_reg_map.sv */
/*
  Maps a bank and a register number to the data-memory address of the register.
  Assumes four banks of eight bytes, bank 0 at the top of the space.
*/
`timescale 1ns/100ps
module bank_reg_map
  import oag_pkg::*;
#(
  parameter logic [15:0] BANK_BASE = 16'hFEE0
) (
  bank_addr_if.map bus
);
  logic [4:0] slot;
  // pairs sit on even addresses, regs low byte first
  always_comb begin
    slot = {~bus.bank, (bus.wide ? {bus.reg_sel[1:0], 1'b0} : bus.reg_sel)};
    bus.loc = BANK_BASE + {11'h000, slot};
  end
endmodule : bank_reg_map

/* File: logic/operand_address_generator.sv */
/*
  Operand effective-address generation for all data addressing modes.
  Assumes the core supplies decoded mode, immediates and register contents.
*/
// Summary of operation
// - a register field names one of eight byte registers or four pairs, by either name.
// - a 3-bit opcode field picks a byte register inside the active bank.
// - register mode uses the bank from the two bank-select flags; other modes only report it.
// - direct mode passes the 16-bit immediate unchanged as the address.
// - short direct maps an 8-bit immediate into the window FE20H to FF1FH.
// - short direct clears address bit 8 for 20H..FFH and sets it for 00H..1FH.
// - a word short direct operand must sit at an even address.
// - sfr mode forms FF00H plus the immediate, reaching FF00H..FFCFH and FFE0H..FFFFH.
// - FF00H..FF1FH decodes the same in short direct and sfr modes.
// - a word sfr operand names an even address and is accessed as one word.
// - indirect mode uses the pair contents as the address, reaching all memory.
// - based mode adds the zero-extended byte offset to the base pair, dropping the carry.
// - indexed mode adds the zero-extended index register to the base pair, dropping the carry.
// - stack accesses are addressed through the stack pointer.
// - stack addressing targets only the internal high-speed ram.
`timescale 1ns/100ps
module operand_address_generator
  import oag_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [3:0] i_mode,
  input wire logic i_wide,
  input wire logic [2:0] i_reg_sel,
  input wire logic i_bank_select_low,
  input wire logic i_bank_select_high,
  input wire logic [15:0] i_imm16,
  input wire logic [7:0] i_imm8,
  input wire logic [15:0] i_pair_value,
  input wire logic [15:0] i_base_value,
  input wire logic [7:0] i_index_value,
  input wire logic [15:0] i_stack_pointer,
  output logic o_valid,
  output logic [15:0] o_addr,
  output logic o_wide,
  output logic o_is_register,
  output logic o_is_sfr,
  output logic [1:0] o_bank,
  output logic [2:0] o_reg_sel,
  output logic o_misaligned,
  output logic o_out_of_range
);
  typedef struct packed {
    state_e state;
    logic valid;
    logic [15:0] addr;
    logic wide;
    logic is_register;
    logic is_sfr;
    logic [1:0] bank;
    logic [2:0] reg_sel;
    logic misaligned;
    logic out_of_range;
  } regs_s;

  regs_s r;
  regs_s next_r;
  bank_addr_if map_bus();
  logic [1:0] bank;
  logic [15:0] short_addr;
  logic [15:0] sum_based;
  logic [15:0] sum_index;

  bank_reg_map u_map (
    .bus(map_bus)
  );

  assign bank = {i_bank_select_high, i_bank_select_low};
  assign map_bus.bank = bank;
  // pairs use the low two bits of the field
  assign map_bus.reg_sel = i_reg_sel;
  assign map_bus.wide = i_wide;
  assign short_addr = {SHORT_TOP, (i_imm8 < SHORT_SPLIT), i_imm8};
  assign sum_based = i_base_value + {8'h00, i_imm8};
  assign sum_index = i_base_value + {8'h00, i_index_value};

  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    case (r.state)
      ST_IDLE: begin
        if (i_start) begin
          next_r.state = ST_DONE;
          next_r.valid = 1'b1;
          next_r.wide = i_wide;
          next_r.is_register = 1'b0;
          next_r.is_sfr = 1'b0;
          next_r.bank = bank;
          next_r.reg_sel = i_reg_sel;
          next_r.misaligned = 1'b0;
          next_r.out_of_range = 1'b0;
          case (mode_e'(i_mode))
            MODE_REG: begin
              next_r.is_register = 1'b1;
              next_r.addr = map_bus.loc;
            end
            MODE_DIRECT: begin
              next_r.addr = i_imm16;
            end
            MODE_SHORT: begin
              next_r.addr = short_addr;
              next_r.is_sfr = (short_addr[15:8] == SFR_PAGE);
              next_r.misaligned = i_wide & i_imm8[0];
            end
            MODE_SFR: begin
              next_r.addr = {SFR_PAGE, i_imm8};
              next_r.is_sfr = 1'b1;
              next_r.misaligned = i_wide & i_imm8[0];
              next_r.out_of_range = (i_imm8 >= SFR_GAP_LO) && (i_imm8 <= SFR_GAP_HI);
            end
            MODE_INDIRECT: begin
              next_r.addr = i_pair_value;
            end
            MODE_BASED: begin
              next_r.addr = sum_based;
            end
            MODE_INDEXED: begin
              next_r.addr = sum_index;
            end
            MODE_STACK: begin
              next_r.addr = i_stack_pointer;
              next_r.out_of_range = (i_stack_pointer < HSRAM_LO_DEF) || (i_stack_pointer > HSRAM_HI_DEF);
            end
            default: begin
              next_r.addr = i_imm16;
              next_r.out_of_range = 1'b1;
            end
          endcase
        end
      end
      ST_DONE: begin
        next_r.state = ST_IDLE;
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '{state: ST_IDLE, valid: 1'b0, addr: 16'h0000, wide: 1'b0, is_register: 1'b0,
             is_sfr: 1'b0, bank: 2'h0, reg_sel: 3'h0, misaligned: 1'b0, out_of_range: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign o_valid = r.valid;
  assign o_addr = r.addr;
  assign o_wide = r.wide;
  assign o_is_register = r.is_register;
  assign o_is_sfr = r.is_sfr;
  assign o_bank = r.bank;
  assign o_reg_sel = r.reg_sel;
  assign o_misaligned = r.misaligned;
  assign o_out_of_range = r.out_of_range;
endmodule : operand_address_generator

/* File: tb/oag_assertions.sv */
/* Port checker for operand_address_generator.
   Assumes one clock and an async active-high reset. */
`timescale 1ns/100ps
module oag_assertions
  import oag_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [3:0] i_mode,
  input wire logic i_bank_select_low,
  input wire logic i_bank_select_high,
  input wire logic [15:0] i_imm16,
  input wire logic [7:0] i_imm8,
  input wire logic [15:0] i_pair_value,
  input wire logic [15:0] i_base_value,
  input wire logic [7:0] i_index_value,
  input wire logic [15:0] i_stack_pointer,
  input wire logic o_valid,
  input wire logic [15:0] o_addr,
  input wire logic [1:0] o_bank
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic take;
  assign take = i_start && !o_valid;
  a_valid_one_pulse: assert property (take |=> o_valid ##1 !o_valid) else $error("valid pulse");
  a_reg_bank_sel: assert property (take && i_mode == MODE_REG |=>
    o_bank == {$past(i_bank_select_high), $past(i_bank_select_low)}) else $error("bank");
  a_direct_addr: assert property (take && i_mode == MODE_DIRECT |=>
    o_addr == $past(i_imm16)) else $error("direct");
  a_short_window: assert property (take && i_mode == MODE_SHORT |=>
    o_addr == {7'h7F, $past(i_imm8) < 8'h20, $past(i_imm8)}) else $error("short");
  a_sfr_page: assert property (take && i_mode == MODE_SFR |=>
    o_addr == {8'hFF, $past(i_imm8)}) else $error("sfr");
  a_indirect_pair: assert property (take && i_mode == MODE_INDIRECT |=>
    o_addr == $past(i_pair_value)) else $error("indirect");
  a_based_sum: assert property (take && i_mode == MODE_BASED |=>
    o_addr == 16'($past(i_base_value) + $past(i_imm8))) else $error("based");
  a_indexed_sum: assert property (take && i_mode == MODE_INDEXED |=>
    o_addr == 16'($past(i_base_value) + $past(i_index_value))) else $error("indexed");
  a_stack_ptr: assert property (take && i_mode == MODE_STACK |=>
    o_addr == $past(i_stack_pointer)) else $error("stack");
endmodule : oag_assertions

/* File: tb/data_space_model.sv */
/* Behavioural data space fed by the generated address.
   Assumes one valid pulse per address. */
`timescale 1ns/100ps
module data_space_model (
  input wire logic i_core_clk,
  input wire logic i_valid,
  input wire logic [15:0] i_addr,
  input wire logic i_wide,
  output logic [15:0] o_word
);
  // word reads pair the even byte with its odd neighbour
  // holds the last word between address pulses
  always_ff @(posedge i_core_clk) begin
    if (i_valid) begin
      o_word <= i_wide ? {i_addr[7:1], 1'b1, i_addr[7:1], 1'b0} : {8'h00, i_addr[7:0]};
    end
  end
endmodule : data_space_model

/* File: tb/test_operand_address_generator.sv */
/* Self-checking bench for operand_address_generator.
   Assumes package, design, checker and data model compiled first. */
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("Error %0t got %h exp %h", $time, a, e); end end
module test_operand_address_generator;
  import oag_pkg::*;
  logic i_core_clk = 0, i_rst = 1, i_start = 0, i_wide = 0, i_bank_select_low = 0, i_bank_select_high = 0;
  logic [3:0] i_mode = 0;
  logic [2:0] i_reg_sel = 0;
  logic [15:0] i_imm16 = 0, i_pair_value = 0, i_base_value = 0, i_stack_pointer = 0;
  logic [7:0] i_imm8 = 0, i_index_value = 0;
  logic o_valid, o_wide, o_is_register, o_is_sfr, o_misaligned, o_out_of_range;
  logic [15:0] o_addr, mem_word;
  logic [1:0] o_bank;
  logic [2:0] o_reg_sel;
  int err_count = 0, n_tests = 0;
  always #25 i_core_clk = ~i_core_clk;
  operand_address_generator dut_u (.*);
  data_space_model mem_u (.i_core_clk(i_core_clk), .i_valid(o_valid), .i_addr(o_addr), .i_wide(o_wide),
    .o_word(mem_word));
  task automatic op(input logic [3:0] m, input logic [7:0] b, input logic [15:0] exp);
    @(negedge i_core_clk);
    i_mode = m;
    i_imm8 = b;
    i_start = 1;
    @(negedge i_core_clk);
    i_start = 0;
    `CHK(o_valid, 1'b1)
    `CHK(o_addr, exp)
  endtask : op
  task automatic t_reg;
    i_reg_sel = REG_C;
    for (int k = 0; k < 4; k++) begin
      {i_bank_select_high, i_bank_select_low} = k[1:0];
      op(MODE_REG, 0, 16'hFEE0 + {~k[1:0], REG_C});
      `CHK(o_bank, k[1:0])
      `CHK(o_is_register, 1'b1)
      `CHK(o_reg_sel, REG_C)
    end
    i_wide = 1;
    i_reg_sel = 3'h7;
    op(MODE_REG, 0, 16'hFEE6);
    `CHK(o_wide, 1'b1)
    i_wide = 0;
  endtask : t_reg
  task automatic t_short;
    logic [7:0] v[4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};
    logic [15:0] w[4] = '{16'hFF00, 16'hFF1F, 16'hFE20, 16'hFEFF};
    foreach (v[k]) op(MODE_SHORT, v[k], w[k]);
    op(MODE_SHORT, 8'h10, 16'hFF10);
    `CHK(o_is_sfr, 1'b1)
    i_wide = 1;
    op(MODE_SHORT, 8'h21, 16'hFE21);
    `CHK(o_misaligned, 1'b1)
    op(MODE_SFR, 8'h22, 16'hFF22);
    `CHK(o_misaligned, 1'b0)
    @(negedge i_core_clk);
    `CHK(mem_word, 16'h2322)
    i_wide = 0;
  endtask : t_short
  task automatic t_sfr;
    op(MODE_SFR, 8'h10, 16'hFF10);
    op(MODE_SFR, 8'hD0, 16'hFFD0);
    `CHK(o_out_of_range, 1'b1)
    op(MODE_SFR, 8'hE0, 16'hFFE0);
    `CHK(o_out_of_range, 1'b0)
  endtask : t_sfr
  task automatic t_ptr;
    i_imm16 = 16'hFE00;
    i_pair_value = 16'hFFFF;
    i_base_value = 16'hFFF0;
    i_index_value = 8'h10;
    op(MODE_DIRECT, 0, 16'hFE00);
    op(MODE_INDIRECT, 0, 16'hFFFF);
    op(MODE_BASED, 8'h20, 16'h0010);
    op(MODE_INDEXED, 0, 16'h0000);
  endtask : t_ptr
  task automatic t_stack;
    i_stack_pointer = 16'hFB00;
    op(MODE_STACK, 0, 16'hFB00);
    `CHK(o_out_of_range, 1'b0)
    i_stack_pointer = 16'hFF00;
    op(MODE_STACK, 0, 16'hFF00);
    `CHK(o_out_of_range, 1'b1)
  endtask : t_stack
  task automatic end_sim;
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(negedge i_core_clk);
    i_rst = 0;
    t_reg();
    t_short();
    t_sfr();
    t_ptr();
    t_stack();
    end_sim();
  end
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
endmodule : test_operand_address_generator
bind operand_address_generator oag_assertions chk_u (.*);
